// [rtl/bfcc_ctrl.sv]
// host-side command controller for a byte-wide, block-erasable flash
// assumes the flash pins are wired straight out, ready_busy_n pulled up on the board
module bfcc_ctrl #(
    parameter int RECOVER_CYC = bfcc_pkg::RECOVER_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic powerDown,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire bfcc_pkg::bfcc_op_e cmdOp,
    input wire logic [18:0] cmdAddr,
    input wire logic [7:0] cmdData0,
    input wire logic [7:0] cmdData1,
    output logic respValid,
    output logic [7:0] respData,
    output logic busyPin,
    output logic [18:0] flashAddr,
    output logic [7:0] dqOut,
    output logic dqOe,
    input wire logic [7:0] dqIn,
    output logic ceN,
    output logic oeN,
    output logic weN,
    output logic reset_powerdown_n,
    input wire logic ready_busy_n
);
    if (RECOVER_CYC < 1 || RECOVER_CYC > 255) begin : gChk
        $error("bfcc_ctrl: RECOVER_CYC out of range");
    end

    typedef enum logic [3:0] {
        ST_PWRDN, ST_RECOVER, ST_IDLE, ST_ISSUE, ST_WAIT,
        ST_PCMD, ST_PCMD_W, ST_PRD, ST_PRD_W, ST_RESP
    } bfcc_st_e;

    bfcc_cyc_if cyc ();
    bfcc_st_e state, next_state;
    logic [7:0] recCnt;
    logic rb1, rb2, rb3;
    logic [18:0] seqAddr [3];
    logic [7:0] seqData [3];
    logic [1:0] seqLen, seqIdx;
    logic wantRead, wantPoll, autoOp;
    logic [18:0] ldAddr [3];
    logic [7:0] ldData [3];
    logic [1:0] ldLen;
    logic ldRead, ldPoll;
    bfcc_pkg::bfcc_op_e selOp;
    logic [18:0] blockAddr;
    logic [1:0] lastIdx;

    assign blockAddr = {cmdAddr[18:14], 14'h0000};
    assign lastIdx = wantRead ? seqLen : seqLen - 2'd1;
    // first op after recovery is the protect-set confirm
    assign selOp = (state == ST_RECOVER) ? bfcc_pkg::OP_PROTECT_SET : cmdOp;

    // command write cycles for each operation
    always_comb begin
        ldAddr[0] = bfcc_pkg::ADDR_ZERO;
        ldAddr[1] = cmdAddr;
        ldAddr[2] = cmdAddr;
        ldData[0] = bfcc_pkg::CMD_READ_ARRAY;
        ldData[1] = bfcc_pkg::CMD_CONFIRM;
        ldData[2] = cmdData1;
        ldLen = 2'd1;
        ldRead = 1'b0;
        ldPoll = 1'b1;
        case (selOp)
            bfcc_pkg::OP_READ: begin
                ldRead = 1'b1;
                ldPoll = 1'b0;
            end
            bfcc_pkg::OP_READ_STATUS: begin
                ldData[0] = bfcc_pkg::CMD_READ_STATUS;
                ldRead = 1'b1;
                ldPoll = 1'b0;
            end
            bfcc_pkg::OP_CLEAR_STATUS: begin
                ldData[0] = bfcc_pkg::CMD_CLEAR_STATUS;
                ldPoll = 1'b0;
            end
            bfcc_pkg::OP_WRITE: begin
                ldData[0] = bfcc_pkg::CMD_WRITE;
                ldData[1] = cmdData0;
                ldLen = 2'd2;
            end
            bfcc_pkg::OP_WRITE2: begin
                ldData[0] = bfcc_pkg::CMD_WRITE2;
                ldData[1] = cmdData0;
                ldLen = 2'd3;
            end
            bfcc_pkg::OP_ERASE: begin
                ldData[0] = bfcc_pkg::CMD_ERASE;
                ldAddr[1] = blockAddr;
                ldLen = 2'd2;
            end
            bfcc_pkg::OP_ERASE_ALL: begin
                ldData[0] = bfcc_pkg::CMD_ERASE_ALL;
                ldLen = 2'd2;
            end
            bfcc_pkg::OP_SUSPEND: begin
                ldData[0] = bfcc_pkg::CMD_SUSPEND;
            end
            bfcc_pkg::OP_RESUME: begin
                ldData[0] = bfcc_pkg::CMD_CONFIRM;
                ldPoll = 1'b0;
            end
            bfcc_pkg::OP_PROTECT_SET: begin
                ldData[0] = bfcc_pkg::CMD_PROTECT_SET;
                ldAddr[1] = bfcc_pkg::PROTECT_ADDR;
                ldLen = 2'd2;
            end
            bfcc_pkg::OP_LOCK: begin
                ldData[0] = bfcc_pkg::CMD_LOCK;
                ldAddr[1] = blockAddr;
                ldLen = 2'd2;
            end
            default: ldPoll = 1'b0;
        endcase
        if (ldRead) begin
            ldAddr[1] = cmdAddr;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_PWRDN: next_state = ST_RECOVER;
            ST_RECOVER: begin
                if (recCnt == 8'h01) begin
                    next_state = ST_ISSUE;
                end
            end
            ST_IDLE: begin
                if (cmdValid) begin
                    next_state = ST_ISSUE;
                end
            end
            ST_ISSUE: next_state = ST_WAIT;
            ST_WAIT: begin
                if (cyc.done && seqIdx == lastIdx) begin
                    next_state = wantPoll ? ST_PCMD : ST_RESP;
                end else if (cyc.done) begin
                    next_state = ST_ISSUE;
                end
            end
            ST_PCMD: next_state = ST_PCMD_W;
            ST_PCMD_W: begin
                if (cyc.done) begin
                    next_state = ST_PRD;
                end
            end
            ST_PRD: next_state = ST_PRD_W;
            ST_PRD_W: begin
                if (cyc.done) begin
                    next_state = cyc.rdata[bfcc_pkg::STAT_READY_BIT] ? ST_RESP : ST_PRD;
                end
            end
            ST_RESP: next_state = ST_IDLE;
            default: next_state = ST_PWRDN;
        endcase
        if (powerDown) begin
            next_state = ST_PWRDN;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_PWRDN;
            reset_powerdown_n <= 1'b0;
            recCnt <= 8'h00;
            cmdReady <= 1'b0;
        end else begin
            state <= next_state;
            reset_powerdown_n <= (next_state != ST_PWRDN);
            recCnt <= (state == ST_PWRDN) ? 8'(RECOVER_CYC) : recCnt - 8'h01;
            cmdReady <= (next_state == ST_IDLE);
        end
    end

    // sequence registers loaded when an operation is accepted
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                seqAddr[i] <= 19'h00000;
                seqData[i] <= 8'h00;
            end
            seqLen <= 2'd0;
            seqIdx <= 2'd0;
            wantRead <= 1'b0;
            wantPoll <= 1'b0;
            autoOp <= 1'b0;
        end else if ((state == ST_IDLE || state == ST_RECOVER) && next_state == ST_ISSUE) begin
            seqAddr <= ldAddr;
            seqData <= ldData;
            seqLen <= ldLen;
            seqIdx <= 2'd0;
            wantRead <= ldRead;
            wantPoll <= ldPoll;
            autoOp <= (state == ST_RECOVER);
        end else if (state == ST_WAIT && cyc.done && seqIdx != lastIdx) begin
            seqIdx <= seqIdx + 2'd1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cyc.req <= 1'b0;
            cyc.isRead <= 1'b0;
            cyc.addr <= 19'h00000;
            cyc.wdata <= 8'h00;
        end else begin
            cyc.req <= 1'b0;
            if (state == ST_ISSUE) begin
                cyc.req <= 1'b1;
                cyc.isRead <= wantRead && seqIdx == seqLen;
                cyc.addr <= seqAddr[seqIdx];
                cyc.wdata <= seqData[seqIdx];
            end else if (state == ST_PCMD || state == ST_PRD) begin
                cyc.req <= 1'b1;
                cyc.isRead <= (state == ST_PRD);
                cyc.addr <= bfcc_pkg::ADDR_ZERO;
                cyc.wdata <= bfcc_pkg::CMD_READ_STATUS;
            end
        end
    end

    assign cyc.abort = powerDown;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            respValid <= 1'b0;
            respData <= 8'h00;
        end else begin
            respValid <= (state == ST_RESP) && !autoOp && !powerDown;
            if (cyc.done) begin
                respData <= cyc.rdata;
            end
        end
    end

    // ready/busy pin synchroniser, low means the flash is working
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rb1 <= 1'b1;
            rb2 <= 1'b1;
            rb3 <= 1'b1;
            busyPin <= 1'b0;
        end else begin
            rb1 <= ready_busy_n;
            rb2 <= rb1;
            rb3 <= rb2;
            if (rb2 == rb3) begin
                busyPin <= !rb3;
            end
        end
    end

    bfcc_bus_cycle u_bus (
        .core_clk(core_clk),
        .rst(rst),
        .cyc(cyc.bus),
        .flashAddr(flashAddr),
        .dqOut(dqOut),
        .dqOe(dqOe),
        .dqIn(dqIn),
        .ceN(ceN),
        .oeN(oeN),
        .weN(weN)
    );
endmodule : bfcc_ctrl

// [inc/bfcc_pkg.sv]
// constants, opcodes and timing counts for the flash command controller
// assumes a 50 MHz core clock and one byte-wide block-erasable flash on the pins
package bfcc_pkg;
    localparam int CLK_MHZ = 50;
    localparam int ADDR_W = 19;
    localparam int BLOCK_OFF_W = 14;
    localparam int BLOCK_SEL_W = 5;
    localparam int BLOCK_BYTES = 16384;
    localparam int T_RECOVER_NS = 550;
    localparam int T_WE_NS = 60;
    localparam int T_READ_NS = 100;
    localparam int RECOVER_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_CYC = (T_WE_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int STAT_READY_BIT = 7;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_WRITE = 8'h40;
    localparam logic [7:0] CMD_WRITE2 = 8'hfb;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL = 8'ha7;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_PROTECT_SET = 8'h57;
    localparam logic [7:0] CMD_LOCK = 8'h77;
    localparam logic [18:0] PROTECT_ADDR = 19'h000ff;
    localparam logic [18:0] ADDR_ZERO = 19'h00000;
    typedef enum logic [3:0] {
        OP_READ,
        OP_READ_STATUS,
        OP_CLEAR_STATUS,
        OP_WRITE,
        OP_WRITE2,
        OP_ERASE,
        OP_ERASE_ALL,
        OP_SUSPEND,
        OP_RESUME,
        OP_PROTECT_SET,
        OP_LOCK
    } bfcc_op_e;
endpackage : bfcc_pkg

// [inc/bfcc_cyc_if.sv]
// one flash bus cycle request between the sequencer and the pin engine
// assumes both ends run on core_clk
interface bfcc_cyc_if;
    logic req;
    logic isRead;
    logic abort;
    logic [18:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output req, isRead, abort, addr, wdata, input done, rdata);
    modport bus (input req, isRead, abort, addr, wdata, output done, rdata);
endinterface : bfcc_cyc_if

// [rtl/bfcc_bus_cycle.sv]
// pin engine: runs one write or one read cycle on the flash pins
// assumes one request at a time, next request only after done
module bfcc_bus_cycle #(
    parameter int WE_CYC = bfcc_pkg::WE_CYC,
    parameter int READ_CYC = bfcc_pkg::READ_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    bfcc_cyc_if.bus cyc,
    output logic [18:0] flashAddr,
    output logic [7:0] dqOut,
    output logic dqOe,
    input wire logic [7:0] dqIn,
    output logic ceN,
    output logic oeN,
    output logic weN
);
    if (WE_CYC < 1 || READ_CYC < 1 || WE_CYC > 255 || READ_CYC > 250) begin : gChk
        $error("bfcc_bus_cycle: strobe counts out of range");
    end

    typedef enum logic [2:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD, B_READ} bfcc_bst_e;
    bfcc_bst_e bst;
    logic [7:0] cnt;
    logic [7:0] dq1, dq2, dq3;

    // data pins cross in from outside through three stages
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dq1 <= 8'h00;
            dq2 <= 8'h00;
            dq3 <= 8'h00;
        end else begin
            dq1 <= dqIn;
            dq2 <= dq1;
            dq3 <= dq2;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bst <= B_IDLE;
            cnt <= 8'h00;
            flashAddr <= 19'h00000;
            dqOut <= 8'h00;
            dqOe <= 1'b0;
            ceN <= 1'b1;
            oeN <= 1'b1;
            weN <= 1'b1;
            cyc.done <= 1'b0;
            cyc.rdata <= 8'h00;
        end else if (cyc.abort) begin
            bst <= B_IDLE;
            dqOe <= 1'b0;
            ceN <= 1'b1;
            oeN <= 1'b1;
            weN <= 1'b1;
            cyc.done <= 1'b0;
        end else begin
            cyc.done <= 1'b0;
            case (bst)
                B_IDLE: begin
                    if (cyc.req) begin
                        flashAddr <= cyc.addr;
                        ceN <= 1'b0;
                        if (cyc.isRead) begin
                            oeN <= 1'b0;
                            cnt <= 8'(READ_CYC + 2);
                            bst <= B_READ;
                        end else begin
                            dqOut <= cyc.wdata;
                            dqOe <= 1'b1;
                            bst <= B_SETUP;
                        end
                    end
                end
                B_SETUP: begin
                    weN <= 1'b0;
                    cnt <= 8'(WE_CYC);
                    bst <= B_STROBE;
                end
                B_STROBE: begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h01) begin
                        weN <= 1'b1;
                        bst <= B_HOLD;
                    end
                end
                B_HOLD: begin
                    dqOe <= 1'b0;
                    ceN <= 1'b1;
                    cyc.done <= 1'b1;
                    bst <= B_IDLE;
                end
                B_READ: begin
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else if (dq2 == dq3) begin
                        cyc.rdata <= dq3;
                        oeN <= 1'b1;
                        ceN <= 1'b1;
                        cyc.done <= 1'b1;
                        bst <= B_IDLE;
                    end
                end
                default: bst <= B_IDLE;
            endcase
        end
    end
endmodule : bfcc_bus_cycle

// [tb/bfcc_ctrl_sva.sv]
// timing checks on the controller's user port and flash pins
// assumes a bind into bfcc_ctrl, one clock domain
module bfcc_ctrl_sva #(
    parameter int RECOVER_CYC = bfcc_pkg::RECOVER_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic powerDown,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire logic respValid,
    input wire logic busyPin,
    input wire logic [18:0] flashAddr,
    input wire logic [7:0] dqOut,
    input wire logic dqOe,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic reset_powerdown_n,
    input wire logic ready_busy_n
);
    int recCnt;
    // cycles since the flash left deep power-down
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            recCnt <= 0;
        end else if (!reset_powerdown_n) begin
            recCnt <= 0;
        end else if (recCnt < 255) begin
            recCnt <= recCnt + 1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_pd_holds_rp: assert property (powerDown [*3] |-> !reset_powerdown_n)
        else $error("power-down request did not hold the flash reset");
    a_pd_pins_idle: assert property ($past(!reset_powerdown_n) && !reset_powerdown_n
        |-> ceN && weN && oeN && !dqOe) else $error("pins active in deep power-down");
    a_recover_wait: assert property (!ceN |-> recCnt >= RECOVER_CYC - 1)
        else $error("flash selected too soon after power-down exit");
    a_we_width: assert property ($fell(weN) |-> !weN [*3] ##1 weN)
        else $error("write enable pulse has the wrong width");
    a_we_rise_hold: assert property ($rose(weN) |-> !ceN && $stable(flashAddr) && $stable(dqOut))
        else $error("address or data moved at write enable rise");
    a_write_drive: assert property (!weN |-> !ceN && oeN && dqOe)
        else $error("write cycle without select or data drive");
    a_standby_idle: assert property (ceN |-> oeN && weN)
        else $error("strobe active while deselected");
    a_busy_seen: assert property (!ready_busy_n [*6] |-> busyPin)
        else $error("busy line low but busy not reported");
    a_ready_seen: assert property (ready_busy_n [*6] |-> !busyPin)
        else $error("busy reported while line released");
    a_take_drops: assert property (cmdValid && cmdReady |=> !cmdReady && !respValid)
        else $error("command port still ready after a take");
    a_resp_pulse: assert property (respValid |=> !respValid)
        else $error("response longer than one cycle");
endmodule : bfcc_ctrl_sva

// [tb/bfcc_flash_model.sv]
// behavioural byte-wide block-erasable flash with lock bits and busy line
// assumes a pull-up on the busy line in the bench
module bfcc_flash_model #(
    parameter int PROG_CYC = 20,
    parameter int ERASE_CYC = 200
) (
    input wire logic core_clk,
    input wire logic rpN,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [18:0] addr,
    input wire logic [7:0] dqFromHost,
    output logic [7:0] dqToHost,
    output wire rdyBsyN
);
    logic [7:0] mem [int];
    logic [31:0] lockBit = 32'h0;
    logic protectOn, susp, statMode, wrErr, erErr, isErase, drv, capTog, seenTog;
    logic [7:0] pend, capD, pendD, lastVal;
    logic [18:0] capA, pendA;
    int busyCnt;
    function automatic logic [7:0] rd(input logic [18:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
    endfunction : rd
    task automatic erase_blk(input logic [4:0] b);
        for (int i = 0; i < 16384; i++) mem.delete(int'({b, i[13:0]}));
    endtask : erase_blk
    assign drv = rpN && !ceN && !oeN;
    // status stays readable while busy
    assign dqToHost = drv ? (statMode ? {busyCnt == 0 || susp, susp, erErr, wrErr, 4'h0}
        : rd(addr)) : ~lastVal;
    assign rdyBsyN = (rpN && busyCnt != 0 && !susp) ? 1'b0 : 1'bz;
    initial capTog = 0;
    always @(posedge weN) begin
        capA = addr;
        capD = dqFromHost;
        capTog = ~capTog;
    end
    always @(posedge core_clk) begin
        if (drv) lastVal <= dqToHost;
        if (!rpN) begin
            {busyCnt, susp, statMode, pend, wrErr, erErr, protectOn} <= '0;
            seenTog <= capTog;
        end else begin
            if (busyCnt != 0 && !susp) busyCnt <= busyCnt - 1;
            if (capTog != seenTog) begin
                seenTog <= capTog;
                if (pend == 8'h00) begin
                    case (capD)
                        8'hff: statMode <= 0;
                        8'h70: statMode <= 1;
                        8'h50: {wrErr, erErr} <= 2'b00;
                        8'hb0: begin
                            susp <= busyCnt != 0 && isErase;
                            statMode <= 1;
                        end
                        8'hd0: susp <= 0;
                        default: pend <= capD;
                    endcase
                end else begin
                    pend <= 8'h00;
                    statMode <= 1;
                    isErase <= 0;
                    case (pend)
                        8'h40: if (!protectOn || lockBit[capA[18:14]]) wrErr <= 1;
                            else begin
                                mem[int'(capA)] = rd(capA) & capD;
                                busyCnt <= PROG_CYC;
                            end
                        8'hfb: {pend, pendA, pendD} <= {8'hfc, capA, capD};
                        8'hfc: if (!protectOn || lockBit[pendA[18:14]]) wrErr <= 1;
                            else begin
                                mem[int'({pendA[18:1], 1'b0})] = pendD;
                                mem[int'({pendA[18:1], 1'b1})] = capD;
                                busyCnt <= PROG_CYC;
                            end
                        8'h20: if (!protectOn || lockBit[capA[18:14]]) erErr <= 1;
                            else begin
                                erase_blk(capA[18:14]);
                                busyCnt <= ERASE_CYC;
                                isErase <= 1;
                            end
                        8'ha7: begin
                            for (int b = 0; b < 32; b++) if (!lockBit[b]) erase_blk(b[4:0]);
                            busyCnt <= ERASE_CYC;
                        end
                        8'h57: if (capA == 19'h000ff && capD == 8'hd0) protectOn <= 1;
                        8'h77: begin
                            lockBit[capA[18:14]] <= 1;
                            busyCnt <= PROG_CYC;
                        end
                        default: pend <= 8'h00;
                    endcase
                end
            end
        end
    end
endmodule : bfcc_flash_model

// [tb/tb.sv]
// self-checking bench for the flash command controller
// assumes the behavioural flash model and the pin checker beside it
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        bfcc_pkg::bfcc_op_e op;
        logic [18:0] a;
        logic [7:0] d0, d1, exp, mask;
    } bfcc_row_s;
    logic core_clk = 0, rst = 1, powerDown = 0, cmdValid = 0;
    bfcc_pkg::bfcc_op_e cmdOp = bfcc_pkg::OP_READ;
    logic [18:0] cmdAddr = 19'h00000;
    logic [7:0] cmdData0 = 8'h00, cmdData1 = 8'h00, r;
    logic cmdReady, respValid, busyPin, dqOe, ceN, oeN, weN, reset_powerdown_n;
    logic [7:0] respData, dqOut, dqIn;
    logic [18:0] flashAddr;
    wire rdyBsyN;
    int error_cnt = 0, compares = 0;
    bfcc_row_s rows [21] = '{
        '{bfcc_pkg::OP_READ, 19'h00010, 8'h00, 8'h00, 8'hff, 8'hff},
        '{bfcc_pkg::OP_WRITE, 19'h00010, 8'ha5, 8'h00, 8'h80, 8'hf0},
        '{bfcc_pkg::OP_READ, 19'h00010, 8'h00, 8'h00, 8'ha5, 8'hff},
        '{bfcc_pkg::OP_WRITE2, 19'h04020, 8'h12, 8'h34, 8'h80, 8'hf0},
        '{bfcc_pkg::OP_READ, 19'h04020, 8'h00, 8'h00, 8'h12, 8'hff},
        '{bfcc_pkg::OP_READ, 19'h04021, 8'h00, 8'h00, 8'h34, 8'hff},
        '{bfcc_pkg::OP_WRITE, 19'h08000, 8'h5a, 8'h00, 8'h80, 8'hf0},
        '{bfcc_pkg::OP_LOCK, 19'h04000, 8'h00, 8'h00, 8'h80, 8'hf0},
        '{bfcc_pkg::OP_WRITE, 19'h04022, 8'h00, 8'h00, 8'h90, 8'hf0},
        '{bfcc_pkg::OP_READ, 19'h04022, 8'h00, 8'h00, 8'hff, 8'hff},
        '{bfcc_pkg::OP_CLEAR_STATUS, 19'h00000, 8'h00, 8'h00, 8'h00, 8'h00},
        '{bfcc_pkg::OP_READ_STATUS, 19'h00000, 8'h00, 8'h00, 8'h80, 8'hff},
        '{bfcc_pkg::OP_ERASE, 19'h00000, 8'h00, 8'h00, 8'h80, 8'hf0},
        '{bfcc_pkg::OP_READ, 19'h00010, 8'h00, 8'h00, 8'hff, 8'hff},
        '{bfcc_pkg::OP_READ, 19'h08000, 8'h00, 8'h00, 8'h5a, 8'hff},
        '{bfcc_pkg::OP_ERASE_ALL, 19'h00000, 8'h00, 8'h00, 8'h80, 8'hf0},
        '{bfcc_pkg::OP_READ, 19'h08000, 8'h00, 8'h00, 8'hff, 8'hff},
        '{bfcc_pkg::OP_READ, 19'h04020, 8'h00, 8'h00, 8'h12, 8'hff},
        '{bfcc_pkg::OP_PROTECT_SET, 19'h00000, 8'h00, 8'h00, 8'h80, 8'hf0},
        '{bfcc_pkg::OP_SUSPEND, 19'h00000, 8'h00, 8'h00, 8'h80, 8'h80},
        '{bfcc_pkg::OP_RESUME, 19'h00000, 8'h00, 8'h00, 8'h00, 8'h00}
    };
    pullup (rdyBsyN);
    always #10 core_clk = ~core_clk;
    bfcc_ctrl DUT (.core_clk(core_clk), .rst(rst), .powerDown(powerDown), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData0(cmdData0),
        .cmdData1(cmdData1), .respValid(respValid), .respData(respData), .busyPin(busyPin),
        .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .ceN(ceN), .oeN(oeN),
        .weN(weN), .reset_powerdown_n(reset_powerdown_n), .ready_busy_n(rdyBsyN));
    bfcc_flash_model u_flash (.core_clk(core_clk), .rpN(reset_powerdown_n), .ceN(ceN),
        .oeN(oeN), .weN(weN), .addr(flashAddr), .dqFromHost(dqOut), .dqToHost(dqIn),
        .rdyBsyN(rdyBsyN));
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait_flag(input bit sel);
        int n;
        n = 0;
        while ((sel ? respValid : cmdReady) !== 1'b1 && n < 5000) begin
            step(1);
            n++;
        end
        if (n >= 5000) begin
            error_cnt++;
            close_out();
        end
    endtask : wait_flag
    task automatic issue(input bfcc_pkg::bfcc_op_e op, input logic [18:0] a, input logic [7:0] d0,
        input logic [7:0] d1);
        wait_flag(0);
        {cmdOp, cmdAddr, cmdData0, cmdData1} = {op, a, d0, d1};
        cmdValid = 1;
        step(1);
        cmdValid = 0;
    endtask : issue
    task automatic do_cmd(input bfcc_pkg::bfcc_op_e op, input logic [18:0] a, input logic [7:0] d0,
        output logic [7:0] rd);
        issue(op, a, d0, 8'h00);
        wait_flag(1);
        rd = respData;
    endtask : do_cmd
    initial begin
        step(10);
        rst = 0;
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].a, rows[i].d0, rows[i].d1);
            wait_flag(1);
            chk($sformatf("row %0d", i), respData & rows[i].mask, rows[i].exp);
        end
        do_cmd(bfcc_pkg::OP_WRITE, 19'h0c000, 8'h77, r);
        issue(bfcc_pkg::OP_ERASE, 19'h0c000, 8'h00, 8'h00);
        step(40);
        chk("busy line", {7'h00, rdyBsyN}, 8'h00);
        chk("busy flag", {7'h00, busyPin}, 8'h01);
        powerDown = 1;
        step(3);
        chk("rp pin", {7'h00, reset_powerdown_n}, 8'h00);
        chk("busy released", {7'h00, rdyBsyN}, 8'h01);
        powerDown = 0;
        do_cmd(bfcc_pkg::OP_READ_STATUS, 19'h00000, 8'h00, r);
        chk("status after exit", r, 8'h80);
        rst = 1;
        step(3);
        chk("ready in reset", {7'h00, cmdReady}, 8'h00);
        rst = 0;
        do_cmd(bfcc_pkg::OP_WRITE, 19'h00020, 8'h3c, r);
        chk("write after reset", r & 8'hf0, 8'h80);
        do_cmd(bfcc_pkg::OP_READ, 19'h00020, 8'h00, r);
        chk("read after reset", r, 8'h3c);
        close_out();
    end
endmodule : tb
bind bfcc_ctrl bfcc_ctrl_sva #(.RECOVER_CYC(RECOVER_CYC)) u_sva (.core_clk(core_clk), .rst(rst),
    .powerDown(powerDown), .cmdValid(cmdValid), .cmdReady(cmdReady), .respValid(respValid),
    .busyPin(busyPin), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN), .oeN(oeN),
    .weN(weN), .reset_powerdown_n(reset_powerdown_n), .ready_busy_n(ready_busy_n));
